// file: verilog/frs_pkg.sv
package frs_pkg;
  // channel count and field widths
  localparam int NCH = 8;
  localparam int RETRY_W = 3;
  // action configuration byte layout
  localparam int ACT_HI = 7;
  localparam int ACT_LO = 6;
  localparam int RTY_HI = 5;
  localparam int RTY_LO = 3;
  localparam logic [1:0] ACT_CONTINUE = 2'h0;
  localparam logic [2:0] RTY_NONE = 3'h0;
  localparam logic [2:0] DELAY_HARD = 3'h0;
  // configuration reset value: shut down, no restart
  localparam logic [7:0] CFG_RESET = 8'h80;
  // summary byte bit positions
  localparam int SB_BUSY = 7;
  localparam int SB_OFF = 6;
  localparam int SB_VOUT_OV = 5;
  localparam int SB_IOUT_OC = 4;
  localparam int SB_VIN_UV = 3;
  localparam int SB_TEMP = 2;
  localparam int SB_CML = 1;
  localparam int SB_HIGH = 0;
  // word high byte and detail bit positions
  localparam int SW_VOUT = 15;
  localparam int SW_INPUT = 13;
  localparam int SW_MFR = 12;
  localparam int SW_PNG = 11;
  localparam int SV_TON_MAX = 2;
  localparam int SI_OV = 7;
  localparam int SI_UV = 4;
  localparam int ST_OT = 7;
  localparam int ST_UT = 4;
  // turn-off delay and restart holdoff, in microseconds
  localparam int TOFF_DELAY_US = 100;
  localparam int RESTART_HOLD_US = 200;
  localparam int CLK_MHZ = 20;
  localparam int TOFF_CYC = TOFF_DELAY_US * CLK_MHZ;
  localparam int RESTART_CYC = RESTART_HOLD_US * CLK_MHZ;
  localparam int CNT_W = 13;
  typedef enum logic [3:0] {
    FRS_OFF = 4'h1,
    FRS_ON = 4'h2,
    FRS_SEQ_OFF = 4'h4,
    FRS_LATCHED = 4'h8
  } frs_state_e;
endpackage : frs_pkg

// file: verilog/frs_channel.sv
module frs_channel
  import frs_pkg::*;
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  // control
  input  wire logic                 enable,
  input  wire logic                 release_latch,
  input  wire logic                 seq_mode,
  input  wire logic [RETRY_W-1:0]   retry_limit,
  // fault request
  input  wire logic                 shut_req,
  input  wire logic                 shut_retry,
  // state
  output logic                      power_on,
  output logic                      latched
);
  typedef struct packed {
    frs_state_e         st;
    logic [CNT_W-1:0]   cnt;
    logic [RETRY_W-1:0] tries;
    logic               rtry;
  } frs_ch_s;
  frs_ch_s r;
  frs_ch_s next_r;

  // per-channel shutdown, latch and restart sequencer
  always_comb begin
    next_r = r;
    unique case (r.st)
      FRS_OFF: begin
        if (enable) begin
          next_r.st = FRS_ON;
        end
      end
      FRS_ON: begin
        if (!enable) begin
          next_r.st = FRS_OFF;
          next_r.tries = '0; // commanded off resets retry count
        end else if (shut_req) begin
          next_r.rtry = shut_retry;
          next_r.cnt = CNT_W'(TOFF_CYC);
          next_r.st = seq_mode ? FRS_SEQ_OFF : FRS_LATCHED;
          if (!seq_mode) begin
            next_r.cnt = CNT_W'(RESTART_CYC);
          end
        end
      end
      FRS_SEQ_OFF: begin
        if (r.cnt == '0) begin
          next_r.st = FRS_LATCHED;
          next_r.cnt = CNT_W'(RESTART_CYC);
        end else begin
          next_r.cnt = r.cnt - 1'b1;
        end
      end
      FRS_LATCHED: begin
        // off state held until release or allowed retry
        if (release_latch) begin
          next_r.st = FRS_OFF;
          next_r.tries = '0;
        end else if (r.rtry && r.tries < retry_limit) begin
          if (r.cnt == '0) begin
            next_r.tries = r.tries + 1'b1;
            next_r.st = FRS_OFF;
          end else begin
            next_r.cnt = r.cnt - 1'b1;
          end
        end
      end
      default: next_r.st = FRS_OFF;
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '{st: FRS_OFF, cnt: '0, tries: '0, rtry: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign power_on = (r.st == FRS_ON) || (r.st == FRS_SEQ_OFF);
  assign latched  = (r.st == FRS_LATCHED);
endmodule : frs_channel

// file: verilog/frs_top.sv
// Functional notes
// - temp/input fault action 00 keeps running; 01-11 shut channel down
// - retry code 000 keeps faulted output off until latch release
// - retry 001-111 restarts up to global count; off command stops
// - delay field reads 000; faults act on detection without deglitch
// - temp/input fault sets summary, detail bits and alert; input fault also sets input word bit
// - turn-on timeout action 00 continues; 01-11 shut down
// - turn-on timeout restart follows its own retry field
// - turn-on timeout sets high summary, vout word, timeout bit, alert
// - fault shutdown latches channel off; retry or latch release restarts it
// - latch released by pin toggle, on/off command, or bias cycle
// - every fault and warning sets status bits and alert
// - clear faults resets status and alert, not the latched off state
// - summary byte equals low byte of the status word
// - high summary bit set for other faults or power not good
// - output overcurrent bit always reads zero
module frs_top
  import frs_pkg::*;
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  // channel control pins and bias sense
  input  wire logic [NCH-1:0]       channel_on_off_pin,
  input  wire logic                 bias_sense_input,
  // on/off commands and per-channel mode
  input  wire logic [NCH-1:0]       op_on,
  input  wire logic                 op_cmd_strobe,
  input  wire logic [NCH-1:0]       seq_mode,
  input  wire logic [RETRY_W-1:0]   retry_count,
  // configuration writes
  input  wire logic                 cfg_we,
  input  wire logic [2:0]           cfg_sel,
  input  wire logic [7:0]           cfg_wdata,
  input  wire logic                 clear_faults,
  // measured fault events
  input  wire logic                 overtemp_fault,
  input  wire logic                 undertemp_fault,
  input  wire logic                 vin_ov_fault,
  input  wire logic                 vin_uv_fault,
  input  wire logic [NCH-1:0]       ton_max_fault,
  input  wire logic                 vout_ov_fault,
  input  wire logic                 warn_event,
  input  wire logic                 cml_fault,
  input  wire logic                 busy,
  input  wire logic                 power_not_good,
  // configuration readback
  output logic [7:0]                overtemp_fault_action_cfg,
  output logic [7:0]                undertemp_fault_action_cfg,
  output logic [7:0]                input_overvolt_action_cfg,
  output logic [7:0]                input_undervolt_action_cfg,
  output logic [7:0]                turn_on_timeout_action_cfg,
  // status
  output logic [7:0]                fault_summary_byte,
  output logic [15:0]               status_word,
  output logic [7:0]                status_vout,
  output logic [7:0]                status_input,
  output logic [7:0]                status_temp,
  output logic [NCH-1:0]            channel_enable,
  output logic [NCH-1:0]            channel_latched,
  output logic                      alert_line_n
);
  typedef struct packed {
    logic [NCH-1:0] pin_s1;
    logic [NCH-1:0] pin_s2;
    logic [NCH-1:0] pin_d;
    logic           bias_s1;
    logic           bias_s2;
    logic           bias_d;
    logic [4:0][7:0] cfg;
    logic [7:0]     sb;
    logic [15:8]    sw_hi;
    logic [7:0]     sv;
    logic [7:0]     si;
    logic [7:0]     st;
    logic [NCH-1:0] en_q;
    logic [NCH-1:0] lat_q;
    logic           alert_n;
  } frs_top_s;
  frs_top_s r;
  frs_top_s next_r;

  logic [NCH-1:0] ch_on;
  logic [NCH-1:0] ch_lat;
  logic [NCH-1:0] ch_en;
  logic [NCH-1:0] ch_rel;
  logic [NCH-1:0] ch_shut;
  logic [NCH-1:0] ch_rtry;
  logic           adc_shut;
  logic           adc_rtry;
  logic           any_event;

  // action and retry of the measured faults; no deglitch delay applied
  always_comb begin
    adc_shut = 1'b0;
    adc_rtry = 1'b0;
    if (overtemp_fault && r.cfg[0][ACT_HI:ACT_LO] != ACT_CONTINUE) begin
      adc_shut = 1'b1;
      adc_rtry = adc_rtry | (r.cfg[0][RTY_HI:RTY_LO] != RTY_NONE);
    end
    if (undertemp_fault && r.cfg[1][ACT_HI:ACT_LO] != ACT_CONTINUE) begin
      adc_shut = 1'b1;
      adc_rtry = adc_rtry | (r.cfg[1][RTY_HI:RTY_LO] != RTY_NONE);
    end
    if (vin_ov_fault && r.cfg[2][ACT_HI:ACT_LO] != ACT_CONTINUE) begin
      adc_shut = 1'b1;
      adc_rtry = adc_rtry | (r.cfg[2][RTY_HI:RTY_LO] != RTY_NONE);
    end
    if (vin_uv_fault && r.cfg[3][ACT_HI:ACT_LO] != ACT_CONTINUE) begin
      adc_shut = 1'b1;
      adc_rtry = adc_rtry | (r.cfg[3][RTY_HI:RTY_LO] != RTY_NONE);
    end
  end

  // per-channel sequencers
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      // release on pin edge, on/off command or bias return
      assign ch_rel[g] = (r.pin_s2[g] ^ r.pin_d[g]) | op_cmd_strobe | (r.bias_s2 & ~r.bias_d);
      assign ch_en[g] = r.pin_s2[g] & op_on[g] & r.bias_s2; // bias loss stops retries
      assign ch_shut[g] = adc_shut |
                          (ton_max_fault[g] & (r.cfg[4][ACT_HI:ACT_LO] != ACT_CONTINUE));
      assign ch_rtry[g] = (ton_max_fault[g] && r.cfg[4][ACT_HI:ACT_LO] != ACT_CONTINUE)
                          ? (r.cfg[4][RTY_HI:RTY_LO] != RTY_NONE) : adc_rtry;
      frs_channel u_ch (
        .clk           (clk),
        .arst_n        (arst_n),
        .enable        (ch_en[g]),
        .release_latch (ch_rel[g]),
        .seq_mode      (seq_mode[g]),
        .retry_limit   (retry_count),
        .shut_req      (ch_shut[g]),
        .shut_retry    (ch_rtry[g]),
        .power_on      (ch_on[g]),
        .latched       (ch_lat[g])
      );
    end
  endgenerate

  assign any_event = overtemp_fault | undertemp_fault | vin_ov_fault | vin_uv_fault |
                     (|ton_max_fault) | vout_ov_fault | warn_event | cml_fault;

  // synchronisers, configuration and sticky status
  always_comb begin
    next_r = r;
    next_r.pin_s1 = channel_on_off_pin;
    next_r.pin_s2 = r.pin_s1;
    next_r.pin_d = r.pin_s2;
    next_r.bias_s1 = bias_sense_input;
    next_r.bias_s2 = r.bias_s1;
    next_r.bias_d = r.bias_s2;
    if (cfg_we && cfg_sel < 3'h5) begin
      next_r.cfg[cfg_sel] = {cfg_wdata[7:3], DELAY_HARD}; // delay always 000
    end
    // clear drops sticky bits; channel latches untouched
    if (clear_faults) begin
      next_r.sb = '0;
      next_r.sw_hi = '0;
      next_r.sv = '0;
      next_r.si = '0;
      next_r.st = '0;
      next_r.alert_n = 1'b1;
    end
    // new events set after clear so a set wins
    if (overtemp_fault) begin
      next_r.st[ST_OT] = 1'b1;
      next_r.sb[SB_TEMP] = 1'b1;
    end
    if (undertemp_fault) begin
      next_r.st[ST_UT] = 1'b1;
      next_r.sb[SB_TEMP] = 1'b1;
    end
    if (vin_ov_fault) begin
      next_r.si[SI_OV] = 1'b1;
      next_r.sw_hi[SW_INPUT] = 1'b1;
      next_r.sb[SB_HIGH] = 1'b1;
    end
    if (vin_uv_fault) begin
      next_r.si[SI_UV] = 1'b1;
      next_r.sw_hi[SW_INPUT] = 1'b1;
      next_r.sb[SB_VIN_UV] = 1'b1;
    end
    if (|ton_max_fault) begin
      next_r.sv[SV_TON_MAX] = 1'b1;
      next_r.sw_hi[SW_VOUT] = 1'b1;
      next_r.sb[SB_HIGH] = 1'b1;
    end
    if (vout_ov_fault) begin
      next_r.sb[SB_VOUT_OV] = 1'b1;
      next_r.sw_hi[SW_VOUT] = 1'b1;
    end
    if (warn_event) begin
      next_r.sw_hi[SW_MFR] = 1'b1;
      next_r.sb[SB_HIGH] = 1'b1;
    end
    if (cml_fault) begin
      next_r.sb[SB_CML] = 1'b1;
    end
    if (any_event) begin
      next_r.alert_n = 1'b0;
    end
    // live bits: busy, off, power-not-good
    next_r.sb[SB_BUSY] = busy;
    next_r.sb[SB_OFF] = ~(&ch_on);
    next_r.sb[SB_IOUT_OC] = 1'b0;
    next_r.sw_hi[SW_PNG] = power_not_good;
    if (power_not_good) begin
      next_r.sb[SB_HIGH] = 1'b1;
    end
    next_r.en_q = ch_on;
    next_r.lat_q = ch_lat;
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
      r.cfg <= {5{CFG_RESET}};
      r.alert_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from flops
  assign overtemp_fault_action_cfg = r.cfg[0];
  assign undertemp_fault_action_cfg = r.cfg[1];
  assign input_overvolt_action_cfg = r.cfg[2];
  assign input_undervolt_action_cfg = r.cfg[3];
  assign turn_on_timeout_action_cfg = r.cfg[4];
  assign fault_summary_byte = r.sb;
  assign status_word = {r.sw_hi, r.sb};
  assign status_vout = r.sv;
  assign status_input = r.si;
  assign status_temp = r.st;
  assign channel_enable = r.en_q;
  assign channel_latched = r.lat_q;
  assign alert_line_n = r.alert_n;
endmodule : frs_top

// file: sim/frs_chk.sv
module frs_chk
  import frs_pkg::*;
(
  // clock and reset
  input wire logic           clk,
  input wire logic           arst_n,
  // fault and command inputs
  input wire logic           overtemp_fault,
  input wire logic           undertemp_fault,
  input wire logic           vin_uv_fault,
  input wire logic [NCH-1:0] ton_max_fault,
  input wire logic           clear_faults,
  input wire logic [NCH-1:0] seq_mode,
  // design outputs
  input wire logic [7:0]     overtemp_fault_action_cfg,
  input wire logic [7:0]     turn_on_timeout_action_cfg,
  input wire logic [7:0]     fault_summary_byte,
  input wire logic [15:0]    status_word,
  input wire logic [7:0]     status_vout,
  input wire logic [7:0]     status_input,
  input wire logic [7:0]     status_temp,
  input wire logic [NCH-1:0] channel_enable,
  input wire logic [NCH-1:0] channel_latched,
  input wire logic           alert_line_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // status flags one cycle after an event; alert checked for temp and timeout only
  a_temp_flags_set: assert property (overtemp_fault |=> status_temp[ST_OT] && fault_summary_byte[SB_TEMP] && !alert_line_n)
    else $error("temperature fault flags missing");
  a_vin_flags_set: assert property (vin_uv_fault |=> status_input[SI_UV] && fault_summary_byte[SB_VIN_UV] && status_word[SW_INPUT])
    else $error("input undervoltage flags missing");
  a_ton_flags_set: assert property (|ton_max_fault |=> status_vout[SV_TON_MAX] && status_word[SW_VOUT] && fault_summary_byte[SB_HIGH] && !alert_line_n)
    else $error("turn-on timeout flags missing");
  // summary byte layout, delay field and status clear
  a_byte_mirror: assert property (fault_summary_byte == status_word[7:0])
    else $error("summary byte differs from word low byte");
  a_oc_zero: assert property (fault_summary_byte[SB_IOUT_OC] == 1'b0)
    else $error("overcurrent bit set");
  a_delay_field_zero: assert property (overtemp_fault_action_cfg[2:0] == DELAY_HARD && turn_on_timeout_action_cfg[2:0] == DELAY_HARD)
    else $error("delay field not zero");
  a_clear_temp_flags: assert property (clear_faults && !overtemp_fault && !undertemp_fault |=> status_temp == 8'h00)
    else $error("clear left temperature status");
  // shutdown and latching of channel 0
  a_shut_immediate: assert property (overtemp_fault && overtemp_fault_action_cfg[7:6] != ACT_CONTINUE && !seq_mode[0] && channel_enable[0] |=> ##1 !channel_enable[0] && channel_latched[0])
    else $error("channel not shut down");
  a_latch_holds_off: assert property ($rose(channel_latched[0]) |-> !channel_enable[0] [*4])
    else $error("latched channel powered");
  // main scenarios
  c_fault_on: cover property (overtemp_fault && channel_enable[0]);
  c_release: cover property ($fell(channel_latched[0]));
  c_timeout: cover property (|ton_max_fault);
  c_seq_off: cover property (overtemp_fault && seq_mode[0] && channel_enable[0]);
endmodule : frs_chk

bind frs_top frs_chk frs_chk_inst (
  .clk(clk), .arst_n(arst_n), .overtemp_fault(overtemp_fault), .undertemp_fault(undertemp_fault),
  .vin_uv_fault(vin_uv_fault), .ton_max_fault(ton_max_fault), .clear_faults(clear_faults),
  .seq_mode(seq_mode), .overtemp_fault_action_cfg(overtemp_fault_action_cfg),
  .turn_on_timeout_action_cfg(turn_on_timeout_action_cfg), .fault_summary_byte(fault_summary_byte),
  .status_word(status_word), .status_vout(status_vout), .status_input(status_input),
  .status_temp(status_temp), .channel_enable(channel_enable), .channel_latched(channel_latched),
  .alert_line_n(alert_line_n)
);

// file: sim/frs_host.sv
module frs_host (
  // clock
  input  wire logic       clk,
  // configuration and commands
  output logic            cfg_we,
  output logic [2:0]      cfg_sel,
  output logic [7:0]      cfg_wdata,
  output logic            clear_faults,
  output logic            op_cmd_strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus
  initial begin
    cfg_we = 1'b0;
    cfg_sel = 3'h0;
    cfg_wdata = 8'h00;
    clear_faults = 1'b0;
    op_cmd_strobe = 1'b0;
  end
  // one-cycle configuration write, data inverted once released
  task automatic wr_cfg(input logic [2:0] s, input logic [7:0] d);
    @(negedge clk);
    cfg_we = 1'b1;
    cfg_sel = s;
    cfg_wdata = d;
    @(negedge clk);
    cfg_we = 1'b0;
    cfg_wdata = ~d;
  endtask : wr_cfg
  // status clear command
  task automatic clr();
    @(negedge clk);
    clear_faults = 1'b1;
    @(negedge clk);
    clear_faults = 1'b0;
  endtask : clr
  // on/off command, releases latched channels
  task automatic op();
    @(negedge clk);
    op_cmd_strobe = 1'b1;
    @(negedge clk);
    op_cmd_strobe = 1'b0;
  endtask : op
endmodule : frs_host

// file: sim/frs_top_test.sv
module frs_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import frs_pkg::*;
  // stimulus and observed signals
  logic           clk = 1'b0;
  logic           arst_n, bias, busy, png, vo, warn, cml, cfg_we, clear_faults, op_cmd_strobe;
  logic [NCH-1:0] pin, op_on, seq, ton, en, lat;
  logic [2:0]     rc, cfg_sel;
  logic [3:0]     mf;
  logic [7:0]     cfg_wdata, sb, sv, si, st, d, em [5];
  logic [7:0]     cfg [5];
  logic [15:0]    sw;
  logic           al_n;
  int             fail_count = 0;
  int             checks = 0;
  int             c;
  always #25 clk = ~clk;
  frs_host frs_host_inst (.clk(clk), .cfg_we(cfg_we), .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata),
    .clear_faults(clear_faults), .op_cmd_strobe(op_cmd_strobe));
  frs_top frs_top_inst (.clk(clk), .arst_n(arst_n), .channel_on_off_pin(pin), .bias_sense_input(bias),
    .op_on(op_on), .op_cmd_strobe(op_cmd_strobe), .seq_mode(seq), .retry_count(rc), .cfg_we(cfg_we),
    .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata), .clear_faults(clear_faults), .overtemp_fault(mf[0]),
    .undertemp_fault(mf[1]), .vin_ov_fault(mf[2]), .vin_uv_fault(mf[3]), .ton_max_fault(ton),
    .vout_ov_fault(vo), .warn_event(warn), .cml_fault(cml), .busy(busy), .power_not_good(png),
    .overtemp_fault_action_cfg(cfg[0]), .undertemp_fault_action_cfg(cfg[1]),
    .input_overvolt_action_cfg(cfg[2]), .input_undervolt_action_cfg(cfg[3]),
    .turn_on_timeout_action_cfg(cfg[4]), .fault_summary_byte(sb), .status_word(sw), .status_vout(sv),
    .status_input(si), .status_temp(st), .channel_enable(en), .channel_latched(lat), .alert_line_n(al_n));
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  // expected values
  function automatic logic [7:0] exp_cfg(input logic [7:0] v);
    return {v[7:3], DELAY_HARD};
  endfunction : exp_cfg
  function automatic logic [7:0] exp_sb(input int k);
    return 8'h01 << (k < 2 ? SB_TEMP : (k == 2 ? SB_HIGH : SB_VIN_UV));
  endfunction : exp_sb
  // helpers
  task automatic pulse(input int k);
    @(negedge clk) mf[k] = 1'b1;
    @(negedge clk) mf = 4'h0;
  endtask : pulse
  task automatic wait_up(input int n);
    for (int i = 0; i < n && en !== 8'hFF; i++) @(negedge clk);
  endtask : wait_up
  task automatic power_up();
    pin = 8'hFF;
    bias = 1'b1;
    op_on = 8'hFF;
    frs_host_inst.op();
    wait_up(20);
    chk(en, 8'hFF);
  endtask : power_up
  // watchdog
  initial begin
    #1500000;
    fail_count++;
    final_report();
  end
  // main sequence
  initial begin
    {arst_n, bias, busy, png, vo, warn, cml, pin, op_on, seq, ton, mf} = '0;
    rc = 3'h1;
    void'($urandom(32'hb24d1c74));
    repeat (3) @(negedge clk);
    for (int i = 0; i < 5; i++) chk(cfg[i], CFG_RESET);
    for (int i = 0; i < 5; i++) em[i] = CFG_RESET;
    arst_n = 1'b1;
    for (int s = 0; s < 8; s++) begin
      d = 8'($urandom);
      frs_host_inst.wr_cfg(3'(s), d);
      if (s < 5) em[s] = exp_cfg(d);
      for (int i = 0; i < 5; i++) chk(cfg[i], em[i]);
    end
    power_up();
    for (int k = 0; k < 4; k++) begin
      frs_host_inst.wr_cfg(3'(k), 8'h00);
      pulse(k);
      chk(sb, exp_sb(k));
      chk(k < 2 ? st : si, 8'h01 << (k[0] ? ST_UT : ST_OT));
      chk(al_n, 1'b0);
      @(negedge clk);
      chk(en, 8'hFF);
      frs_host_inst.clr();
      chk({al_n, sb}, 9'h100);
      d = {2'(1 + $urandom_range(2)), RTY_NONE, 3'($urandom)};
      frs_host_inst.wr_cfg(3'(k), d);
      pulse(k);
      @(negedge clk);
      chk({en, lat}, 16'h00FF);
      frs_host_inst.clr();
      repeat (20) @(negedge clk);
      chk({en, lat, al_n}, 17'h001FF);
      power_up();
    end
    for (int a = 0; a < 2; a++) begin
      frs_host_inst.wr_cfg(3'h4, a ? 8'h80 : 8'h00);
      c = $urandom_range(NCH - 1);
      @(negedge clk) ton[c] = 1'b1;
      @(negedge clk) ton = '0;
      chk({sv[SV_TON_MAX], sw[SW_VOUT], sb[SB_HIGH]}, 3'h7);
      @(negedge clk);
      chk(lat, a ? 8'h01 << c : 8'h00);
      pin[c] = 1'b0;
      repeat (5) @(negedge clk);
      pin[c] = 1'b1;
      wait_up(20);
      chk({en, lat}, 16'hFF00);
    end
    seq = 8'hFF;
    frs_host_inst.wr_cfg(3'h0, 8'h40);
    pulse(0);
    repeat (100) @(negedge clk);
    chk(en, 8'hFF);
    repeat (TOFF_CYC) @(negedge clk);
    chk(en, 8'h00);
    seq = 8'h00;
    power_up();
    frs_host_inst.wr_cfg(3'h1, 8'hC8);
    pulse(1);
    repeat (3) @(negedge clk);
    chk(en, 8'h00);
    wait_up(RESTART_CYC + 50);
    chk(en, 8'hFF);
    pulse(1);
    repeat (RESTART_CYC + 50) @(negedge clk);
    chk(en, 8'h00);
    bias = 1'b0;
    repeat (5) @(negedge clk);
    bias = 1'b1;
    wait_up(20);
    chk(en, 8'hFF);
    frs_host_inst.clr();
    @(negedge clk) warn = 1'b1;
    @(negedge clk) warn = 1'b0;
    chk(al_n, 1'b0);
    {busy, png, cml, vo} = 4'hF;
    @(negedge clk) {cml, vo} = 2'h0;
    @(negedge clk);
    chk({sb[SB_BUSY], sb[SB_VOUT_OV], sb[SB_CML], sb[SB_HIGH], sw[SW_PNG]}, 5'h1F);
    final_report();
  end
endmodule : frs_top_test
